// file: pkg/spdc_pkg.sv
// Constants, field layout and carrier types of the suspend power-down control block
package spdc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_PWR_CTRL = 16'h0354;
  localparam logic [15:0] ADDR_PWR_STAT = 16'h0358;
  localparam logic [31:0] PWR_CTRL_RST  = 32'h03E8_1BA0;
  // Writable bits; reserved bits hold their reset value
  localparam logic [31:0] PWR_CTRL_WMASK = 32'hFFFF_1C3F;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int HOLD_MSB       = 31;
  localparam int HOLD_LSB       = 16;
  localparam int BIT_P3_PD      = 12;
  localparam int BIT_P2_PD      = 11;
  localparam int BIT_BATT       = 10;
  localparam int BIT_BIAS       = 5;
  localparam int BIT_VREG       = 4;
  localparam int BIT_OC3        = 3;
  localparam int BIT_OC2        = 2;
  localparam int BIT_OC1        = 1;
  localparam int BIT_HC_CLK     = 0;
  localparam int STAT_BIT_SUSP  = 0;
  localparam int STAT_BIT_AWAKE = 1;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int SLOW_PERIOD_NS  = 10_000;
  localparam int SLOW_TICK_CYC   = SLOW_PERIOD_NS / CLK_PERIOD_NS;
  localparam int FIXED_HOLD_MS   = 50;
  localparam int FIXED_HOLD_INT  = FIXED_HOLD_MS * 1_000_000 / SLOW_PERIOD_NS;
  localparam logic [15:0] FIXED_HOLD = 16'(FIXED_HOLD_INT);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SPDC_NORMAL, SPDC_SUSPEND, SPDC_AWAKE} spdc_state_type;

  typedef struct packed {
    logic [15:0] hold;
    logic        third_port_pulldown_off;
    logic        second_port_pulldown_off;
    logic        battery_detector_off;
    logic        bias_keep_on;
    logic        regulator_suspend_off;
    logic        third_port_overcurrent_off;
    logic        second_port_overcurrent_off;
    logic        first_port_overcurrent_off;
    logic        host_core_clock_enable;
  } spdc_ctrl_type;

  typedef struct packed {
    logic       third_port_pulldown_on;
    logic       second_port_pulldown_on;
    logic       battery_detector_power;
    logic       bias_power;
    logic       regulator_power;
    logic [2:0] overcurrent_enable;
    logic       host_core_clock_enable;
  } spdc_pwr_type;

  // Pick the control fields out of a register word
  function automatic spdc_ctrl_type ctrl_from_word(input logic [31:0] w);
    spdc_ctrl_type c;
    c.hold                        = w[HOLD_MSB:HOLD_LSB];
    c.third_port_pulldown_off     = w[BIT_P3_PD];
    c.second_port_pulldown_off    = w[BIT_P2_PD];
    c.battery_detector_off        = w[BIT_BATT];
    c.bias_keep_on                = w[BIT_BIAS];
    c.regulator_suspend_off       = w[BIT_VREG];
    c.third_port_overcurrent_off  = w[BIT_OC3];
    c.second_port_overcurrent_off = w[BIT_OC2];
    c.first_port_overcurrent_off  = w[BIT_OC1];
    c.host_core_clock_enable      = w[BIT_HC_CLK];
    return c;
  endfunction

endpackage

// file: hdl/spdc_pin_sync.sv
// Three-stage synchroniser with agreement filter for the wake pin
`timescale 1ns/100ps
`default_nettype none
module spdc_pin_sync
(
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  input  wire logic i_pin,
  output var  logic o_level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // First stage feeds only the second; level moves once stages two and three agree
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        o_level <= s3_r;
    end
  end

endmodule
`default_nettype wire

// file: hdl/spdc_slow_tick.sv
// Slow wake clock: one-cycle tick every slow period, derived from the system clock
`timescale 1ns/100ps
`default_nettype none
module spdc_slow_tick
(
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  output var  logic o_tick
);

  localparam logic [15:0] LAST = 16'(spdc_pkg::SLOW_TICK_CYC - 1);

  logic [15:0] div_r;

  // Free-running divider, like the on-chip slow oscillator it stands for
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      div_r  <= 16'h0000;
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= (div_r == LAST);
      div_r  <= (div_r == LAST) ? 16'h0000 : div_r + 16'h0001;
    end
  end

endmodule
`default_nettype wire

// file: hdl/spdc_top.sv
// Suspend power-down control register with wake-up hold timer
//
// Behaviour
// - After a wake-up event stay awake for the hold interval, then suspend.
// - Return to suspend is skipped when software restores normal operation first.
// - Hold counter field resets to 03E8h, ten milliseconds.
// - Hold value zero means a wake-up event never wakes the device.
// - Hold value FFFFh gives the longest awake interval, about 655 ms.
// - One hold count is one slow wake clock period, 10 us.
// - In 16-bit mode any hold write sets a fixed 50 ms interval.
// - Third-port pull-downs connected in suspend at 0, disconnected at 1.
// - Second-port pull-downs connected in suspend at 0, disconnected at 1.
// - Field layout: hold 31:16, pulldowns 12:11, battery 10, bias 5, etc.
// - Battery detector powered in suspend at 0, unpowered at 1.
// - Bias unpowered in suspend at 0, powered at 1.
// - Regulators powered in suspend at 0, off at 1.
// - Per-port overcurrent detection on in suspend at 0, off at 1.
`timescale 1ns/100ps
`default_nettype none
module spdc_top
(
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_sys_rst,
  input  wire logic [15:0]           i_addr,
  input  wire logic [31:0]           i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output var  logic [31:0]           o_rdata,
  input  wire logic                  i_bus16_mode,
  input  wire logic                  i_wake_pin,
  input  wire logic                  i_enter_suspend,
  input  wire logic                  i_resume_normal,
  output var  logic                  o_suspended,
  output var  logic                  o_awake,
  output var  logic                  o_suspend_req,
  output var  spdc_pkg::spdc_pwr_type o_pwr
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [31:0]              ctrl_r;
  spdc_pkg::spdc_ctrl_type  ctrl;
  spdc_pkg::spdc_state_type state_r;
  spdc_pkg::spdc_state_type state_nxt;
  logic [15:0]              cnt_r;
  logic                     wake_lvl;
  logic                     wake_lvl_d_r;
  logic                     wake_rise;
  logic                     tick;
  logic                     expire;
  logic                     wr_ctrl;
  logic                     in_susp;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  spdc_pin_sync u_wake_sync
  (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_wake_pin),
    .o_level   (wake_lvl)
  );

  spdc_slow_tick u_slow_tick
  (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .o_tick    (tick)
  );

  // Wake event is the rising edge of the filtered pin level
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      wake_lvl_d_r <= 1'b0;
    else
      wake_lvl_d_r <= wake_lvl;
  end

  assign wake_rise = wake_lvl & ~wake_lvl_d_r;
  assign ctrl      = spdc_pkg::ctrl_from_word(ctrl_r);
  assign wr_ctrl   = i_wr && (i_addr == spdc_pkg::ADDR_PWR_CTRL);
  assign in_susp   = (state_r == spdc_pkg::SPDC_SUSPEND);

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  // Reserved bits are reloaded with their reset value on every write, so a careless write cannot disturb them
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      ctrl_r <= spdc_pkg::PWR_CTRL_RST;
    else if (wr_ctrl)
    begin
      ctrl_r <= (i_wdata & spdc_pkg::PWR_CTRL_WMASK)
              | (spdc_pkg::PWR_CTRL_RST & ~spdc_pkg::PWR_CTRL_WMASK);
      if (i_bus16_mode)
        ctrl_r[spdc_pkg::HOLD_MSB:spdc_pkg::HOLD_LSB] <= spdc_pkg::FIXED_HOLD;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst || !i_rd)
      o_rdata <= 32'h0000_0000;
    else if (i_addr == spdc_pkg::ADDR_PWR_CTRL)
      o_rdata <= ctrl_r;
    else if (i_addr == spdc_pkg::ADDR_PWR_STAT)
    begin
      o_rdata                          <= {cnt_r, 16'h0000};
      o_rdata[spdc_pkg::STAT_BIT_SUSP]  <= in_susp;
      o_rdata[spdc_pkg::STAT_BIT_AWAKE] <= (state_r == spdc_pkg::SPDC_AWAKE);
    end
    else
      o_rdata <= 32'h0000_0000;
  end

  // ---------------------------------------------------------------
  // Suspend sequencer
  // ---------------------------------------------------------------
  // Expiry on the tick that takes the count from one to zero
  assign expire = (state_r == spdc_pkg::SPDC_AWAKE) && tick && (cnt_r == 16'h0001)
                  && !wake_rise && !i_resume_normal;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      spdc_pkg::SPDC_NORMAL:
        if (i_enter_suspend)
          state_nxt = spdc_pkg::SPDC_SUSPEND;
      spdc_pkg::SPDC_SUSPEND:
        if (wake_rise && (ctrl.hold != 16'h0000))
          state_nxt = spdc_pkg::SPDC_AWAKE;
      spdc_pkg::SPDC_AWAKE:
        if (i_resume_normal)
          state_nxt = spdc_pkg::SPDC_NORMAL;
        else if (wake_rise && (ctrl.hold == 16'h0000))
          state_nxt = spdc_pkg::SPDC_SUSPEND;
        else if (expire)
          state_nxt = spdc_pkg::SPDC_SUSPEND;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      state_r <= spdc_pkg::SPDC_NORMAL;
    else
      state_r <= state_nxt;
  end

  // Hold counter: a wake event in suspend or awake reloads, each slow tick while awake counts down
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      cnt_r <= 16'h0000;
    else if (wake_rise && (state_r != spdc_pkg::SPDC_NORMAL))
      cnt_r <= ctrl.hold;
    else if ((state_r == spdc_pkg::SPDC_AWAKE) && tick && (cnt_r != 16'h0000))
      cnt_r <= cnt_r - 16'h0001;
    else if (state_r != spdc_pkg::SPDC_AWAKE)
      cnt_r <= 16'h0000;
  end

  // Suspend request pulse and state flags
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      o_suspend_req <= 1'b0;
      o_suspended   <= 1'b0;
      o_awake       <= 1'b0;
    end
    else
    begin
      o_suspend_req <= expire;
      o_suspended   <= (state_nxt == spdc_pkg::SPDC_SUSPEND);
      o_awake       <= (state_nxt == spdc_pkg::SPDC_AWAKE);
    end
  end

  // ---------------------------------------------------------------
  // Analogue helper controls
  // ---------------------------------------------------------------
  // Outside suspend every helper stays on; all bits but the host core clock enable only bite in suspend
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      o_pwr <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'b111, 1'b0};
    end
    else
    begin
      o_pwr.third_port_pulldown_on  <= !(in_susp && ctrl.third_port_pulldown_off);
      o_pwr.second_port_pulldown_on <= !(in_susp && ctrl.second_port_pulldown_off);
      o_pwr.battery_detector_power  <= !(in_susp && ctrl.battery_detector_off);
      o_pwr.bias_power              <= !in_susp || ctrl.bias_keep_on;
      o_pwr.regulator_power         <= !(in_susp && ctrl.regulator_suspend_off);
      o_pwr.overcurrent_enable      <= ~({3{in_susp}}
                                        & {ctrl.third_port_overcurrent_off,
                                           ctrl.second_port_overcurrent_off,
                                           ctrl.first_port_overcurrent_off});
      o_pwr.host_core_clock_enable  <= ctrl.host_core_clock_enable;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_hold_reset_val: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $past(i_sys_rst) && !$past(wr_ctrl) |-> ctrl.hold == 16'h03E8)
    else $error("hold field not 03E8h after reset");

  a_zero_no_wake: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    in_susp && wake_rise && ctrl.hold == 16'h0000 |=> state_r == spdc_pkg::SPDC_SUSPEND)
    else $error("woke with zero hold");

  a_wake_loads: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    in_susp && wake_rise && ctrl.hold != 16'h0000
    |=> state_r == spdc_pkg::SPDC_AWAKE && cnt_r == $past(ctrl.hold))
    else $error("wake did not load hold counter");

  a_tick_decrement: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    state_r == spdc_pkg::SPDC_AWAKE && tick && !wake_rise && !i_resume_normal
    && cnt_r > 16'h0001 |=> cnt_r == $past(cnt_r) - 16'h0001 && o_awake)
    else $error("hold counter did not step once per slow tick");

  a_expiry_suspend: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    state_r == spdc_pkg::SPDC_AWAKE && tick && cnt_r == 16'h0001
    && !wake_rise && !i_resume_normal
    |=> in_susp && o_suspend_req ##1 !o_suspend_req)
    else $error("no single suspend request on expiry");

  a_resume_wins: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    state_r == spdc_pkg::SPDC_AWAKE && i_resume_normal
    |=> state_r == spdc_pkg::SPDC_NORMAL && !o_suspend_req)
    else $error("resume to normal did not cancel suspend");

  a_fixed_hold16: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    wr_ctrl && i_bus16_mode |=> ctrl.hold == 16'h1388)
    else $error("16-bit write did not fix 50 ms hold");

  a_hold_written: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    wr_ctrl && !i_bus16_mode |=> ctrl.hold == $past(i_wdata[31:16]))
    else $error("hold field not taken from write data");

  a_pulldown_susp: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    in_susp ##1 in_susp |-> o_pwr.third_port_pulldown_on == !$past(ctrl.third_port_pulldown_off)
    && o_pwr.second_port_pulldown_on == !$past(ctrl.second_port_pulldown_off))
    else $error("pull-down control wrong in suspend");

  a_normal_all_on: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    state_r == spdc_pkg::SPDC_NORMAL |=> o_pwr.regulator_power && o_pwr.bias_power
    && o_pwr.battery_detector_power && o_pwr.overcurrent_enable == 3'b111)
    else $error("suspend control acted outside suspend");

  a_read_once: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_rd && i_addr == spdc_pkg::ADDR_PWR_CTRL ##1 !i_rd
    |-> o_rdata == $past(ctrl_r) ##1 o_rdata == 32'h0000_0000)
    else $error("control read data wrong or held too long");

  a_batt_susp: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    in_susp ##1 in_susp
    |-> o_pwr.battery_detector_power == !$past(ctrl.battery_detector_off))
    else $error("battery detector control wrong in suspend");

  a_bias_susp: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    in_susp ##1 in_susp
    |-> o_pwr.bias_power == $past(ctrl.bias_keep_on))
    else $error("bias control wrong in suspend");

  a_vreg_susp: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    in_susp ##1 in_susp
    |-> o_pwr.regulator_power == !$past(ctrl.regulator_suspend_off))
    else $error("regulator control wrong in suspend");

  a_ocp_susp: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    in_susp ##1 in_susp |-> o_pwr.overcurrent_enable == ~{$past(ctrl.third_port_overcurrent_off),
    $past(ctrl.second_port_overcurrent_off), $past(ctrl.first_port_overcurrent_off)})
    else $error("overcurrent control wrong in suspend");

  a_awake_all_on: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    state_r == spdc_pkg::SPDC_AWAKE |=> o_pwr.third_port_pulldown_on && o_pwr.bias_power
    && o_pwr.second_port_pulldown_on && o_pwr.regulator_power && o_pwr.battery_detector_power)
    else $error("suspend control acted while awake");

  a_clock_bit: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    1'b1 |=> o_pwr.host_core_clock_enable == $past(ctrl.host_core_clock_enable))
    else $error("host core clock enable does not follow its bit");

  a_rdata_idle: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data present without a read strobe");

endmodule
`default_nettype wire

// file: test/tb_top.sv
// Self-checking testbench of the suspend power-down control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // ---------------------------------------------------------------
  // Design hookup
  // ---------------------------------------------------------------
  logic                   i_clk_sys = 1'b0;
  logic                   i_sys_rst = 1'b1;
  logic [15:0]            i_addr = 16'h0000;
  logic [31:0]            i_wdata = 32'h0000_0000;
  logic                   i_wr = 1'b0;
  logic                   i_rd = 1'b0;
  logic                   i_bus16_mode = 1'b0;
  logic                   i_wake_pin = 1'b0;
  logic                   i_enter_suspend = 1'b0;
  logic                   i_resume_normal = 1'b0;
  logic [31:0]            o_rdata;
  logic                   o_suspended;
  logic                   o_awake;
  logic                   o_suspend_req;
  spdc_pkg::spdc_pwr_type o_pwr;
  int                     failures = 0;
  int                     compares = 0;
  int                     req_seen = 0;
  logic [31:0]            rd_val;

  spdc_top u_spdc_top (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_bus16_mode(i_bus16_mode), .i_wake_pin(i_wake_pin), .i_enter_suspend(i_enter_suspend),
    .i_resume_normal(i_resume_normal), .o_suspended(o_suspended), .o_awake(o_awake),
    .o_suspend_req(o_suspend_req), .o_pwr(o_pwr));

  // 100 MHz system clock
  always #5 i_clk_sys = ~i_clk_sys;

  // Count expiry pulses so that a resume can be shown to suppress them
  always @(posedge i_clk_sys)
    if (o_suspend_req === 1'b1)
      req_seen++;

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd   <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic pulse_suspend();
    @(posedge i_clk_sys);
    i_enter_suspend <= 1'b1;
    @(posedge i_clk_sys);
    i_enter_suspend <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask

  // Raise the wake pin and poll for the awake state, bounded
  task automatic wake(input int lim, output int n);
    @(posedge i_clk_sys);
    i_wake_pin <= 1'b1;
    n = 0;
    while (o_awake !== 1'b1 && n < lim)
    begin
      @(posedge i_clk_sys);
      #1 n++;
    end
    @(posedge i_clk_sys);
    i_wake_pin <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    #1;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    bus_rd(spdc_pkg::ADDR_PWR_CTRL, rd_val);
    check(rd_val, 32'h03E8_1BA0);
    bus_rd(spdc_pkg::ADDR_PWR_STAT, rd_val);
    check(rd_val, 32'h0000_0000);
    bus_rd(16'h0360, rd_val);
    check(rd_val, 32'h0000_0000);
    check({23'h0, o_pwr[8:1], o_suspended}, {23'h0, 8'hFF, 1'b0});
    check({31'h0, o_pwr[0]}, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_regs();
    bus_wr(spdc_pkg::ADDR_PWR_CTRL, 32'hFFFF_1FBF);
    bus_rd(spdc_pkg::ADDR_PWR_CTRL, rd_val);
    check(rd_val, 32'hFFFF_1FBF);
    check({31'h0, o_pwr[0]}, 32'h1);
    bus_wr(spdc_pkg::ADDR_PWR_CTRL, 32'h0000_0380);
    bus_wr(16'h0360, 32'h1234_5678);
    bus_wr(spdc_pkg::ADDR_PWR_STAT, 32'hFFFF_FFFF);
    bus_rd(spdc_pkg::ADDR_PWR_CTRL, rd_val);
    check(rd_val, 32'h0000_0380);
    check({31'h0, o_pwr[0]}, 32'h0);
    bus_rd(spdc_pkg::ADDR_PWR_STAT, rd_val);
    check(rd_val, 32'h0000_0000);
    $display("test register access done");
  endtask

  // In 16-bit mode the written hold value is replaced by 50 ms worth of ticks
  task automatic t_bus16();
    @(posedge i_clk_sys);
    i_bus16_mode <= 1'b1;
    bus_wr(spdc_pkg::ADDR_PWR_CTRL, 32'h0005_0380);
    bus_rd(spdc_pkg::ADDR_PWR_CTRL, rd_val);
    check(rd_val, 32'h1388_0380);
    @(posedge i_clk_sys);
    i_bus16_mode <= 1'b0;
    $display("test 16-bit mode done");
  endtask

  // Two complementary patterns of the suspend controls, then wake and resume
  task automatic t_pwr();
    logic [15:0] pat [2];
    logic [7:0]  exp [2];
    int          n;
    int          r0;
    pat[0] = 16'h1794;
    exp[0] = 8'h45;
    pat[1] = 16'h0BAA;
    exp[1] = 8'hBA;
    for (int k = 0; k < 2; k++)
    begin
      bus_wr(spdc_pkg::ADDR_PWR_CTRL, {16'h0003, pat[k]});
      pulse_suspend();
      check({31'h0, o_suspended}, 32'h1);
      check({24'h0, o_pwr[8:1]}, {24'h0, exp[k]});
      r0 = req_seen;
      wake(20, n);
      check({31'h0, o_awake}, 32'h1);
      check({24'h0, o_pwr[8:1]}, 32'h0000_00FF);
      bus_rd(spdc_pkg::ADDR_PWR_STAT, rd_val);
      check({16'h0, rd_val[15:0]}, 32'h0000_0002);
      check({31'h0, rd_val[31:16] == 16'h0003 || rd_val[31:16] == 16'h0002}, 32'h1);
      @(posedge i_clk_sys);
      i_resume_normal <= 1'b1;
      @(posedge i_clk_sys);
      i_resume_normal <= 1'b0;
      repeat (4000) @(posedge i_clk_sys);
      #1 check({30'h0, o_awake, o_suspended}, 32'h0);
      check(req_seen - r0, 32'h0);
      check({24'h0, o_pwr[8:1]}, 32'h0000_00FF);
    end
    $display("test power controls done");
  endtask

  // Hold of three ticks: awake time lies within the last tick period
  task automatic t_hold();
    int n;
    int r0;
    bus_wr(spdc_pkg::ADDR_PWR_CTRL, 32'h0003_0380);
    pulse_suspend();
    r0 = req_seen;
    @(posedge i_clk_sys);
    i_wake_pin <= 1'b1;
    n = 0;
    while (o_awake !== 1'b1 && n < 20)
    begin
      @(posedge i_clk_sys);
      #1 n++;
    end
    n = 0;
    while (o_suspended !== 1'b1 && n < 4000)
    begin
      @(posedge i_clk_sys);
      #1 n++;
    end
    check({31'h0, n > 2000 && n <= 3000}, 32'h1);
    check({30'h0, o_suspend_req, o_awake}, 32'h2);
    @(posedge i_clk_sys);
    #1 check({31'h0, o_suspend_req}, 32'h0);
    check(req_seen - r0, 32'h1);
    // Pin stays high through the hold; drop it on an edge and let the filter settle
    @(posedge i_clk_sys);
    i_wake_pin <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    $display("test hold expiry done");
  endtask

  // A zero hold keeps the device in suspend through a wake event
  task automatic t_zero();
    int n;
    bus_wr(spdc_pkg::ADDR_PWR_CTRL, 32'h0000_0380);
    wake(20, n);
    check({30'h0, o_awake, o_suspended}, 32'h1);
    bus_rd(spdc_pkg::ADDR_PWR_STAT, rd_val);
    check(rd_val, 32'h0000_0001);
    $display("test zero hold done");
  endtask

  // ---------------------------------------------------------------
  // Verdict and sequence
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Longest path is two resumes plus one hold run, well below this span
  initial
  begin
    #400_000;
    failures++;
    summarize();
  end

  initial
  begin
    repeat (16) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    t_reset();
    t_regs();
    t_bus16();
    t_pwr();
    t_hold();
    t_zero();
    summarize();
  end
endmodule
`default_nettype wire
